// ===== hw/approximation_register.sv
/*
 * ten-bit successive approximation register: loads the msb trial, then
 * settles one bit per decision and raises the next lower bit as trial.
 * assumes the controller issues begin and decide strobes in sequence.
 */
`timescale 1ns/1ns
module approximation_register (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       begin_in,
    input  wire logic       decide_in,
    input  wire logic [3:0] bit_in,
    input  wire logic       cmp_ge_in,
    output logic      [9:0] value_out
);

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= sar_adc_pkg::RESULT_RESET;
        end else if (ce_in) begin
            if (begin_in) begin
                value_out <= sar_adc_pkg::SAR_MSB_ONLY; // R03
            end else if (decide_in) begin
                value_out[bit_in] <= cmp_ge_in; // R21
                if (bit_in != 4'h0) begin
                    value_out[bit_in - 4'h1] <= 1'b1; // R21
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_msb_first_trial: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R03
        begin_in && ce_in |=> value_out == sar_adc_pkg::SAR_MSB_ONLY)
        else $error("trial did not start at the msb");

    a_bit_keeps_decision: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R21
        decide_in && ce_in && !begin_in |=>
            ((value_out >> $past(bit_in)) & 10'h001) == {9'h000, $past(cmp_ge_in)})
        else $error("decided bit does not follow the comparator");

endmodule

// ===== hw/sar_adc_control.sv
/*
 * control for a ten-bit successive-approximation converter: mode and channel
 * registers, sample/hold and trial sequencing, result registers, done pulse.
 * assumes an analog sample-hold, tap divider and comparator outside; the
 * comparator decision is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
// Summary of operation
// [R01] convert one of four selected inputs
// [R02] sample at start, hold for the rest
// [R03] resolve msb to lsb, then transfer result
// [R04] result word: ten low bits, upper zero
// [R05] high byte gets top eight result bits
// [R06] done pulse on every completed conversion
// [R07] mode register at ff80, reset zero
// [R08] run bit7, timing 5:3, enable bit0
// [R09] run bit zero stops, one starts
// [R10] timing code sets sample and total ticks
// [R11] length covers sampling plus comparison steps
// [R12] enable bit powers the comparator
// [R13] run starts even with comparator off
// [R14] software waits before run after enable
// [R15] stopped, waiting, or converting by bits
// [R16] software waits two cycles before run
// [R17] software stops before changing timing code
// [R18] software keeps conversion under hundred microseconds
// [R19] conversions repeat until run bit cleared
// [R20] mode or channel write restarts conversion
// [R21] set trial bit, keep when input ge
// [R22] sampling begins two to three ticks later
// [R23] trial presented, decision captured once per step
module sar_adc_control (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        cmp_ge_in,
    output logic      [15:0] rdata_out,
    output logic             sample_out,
    output logic      [9:0]  trial_code_out,
    output logic      [1:0]  channel_select_out,
    output logic             comparator_power_out,
    output logic             conversion_done_irq_out,
    output logic      [3:0]  port_pin_usable_out
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0]                 converter_mode_control_q;
    logic [7:0]                 input_channel_select_q;
    logic [15:0]                conversion_result_word_q;
    logic [7:0]                 conversion_result_high_byte_q;
    sar_adc_pkg::conv_state_t   state_q;
    sar_adc_pkg::conv_state_t   state_d;
    logic [7:0]                 cnt_q;
    logic [7:0]                 cnt_d;
    logic [7:0]                 div_q;
    logic                       tick_q;
    logic                       cmp_meta_q;
    logic                       cmp_sync_q;
    logic [9:0]                 sar_value;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    logic       mode_wr;
    logic       chan_wr;
    logic       cfg_wr;
    logic       run_new;
    logic [2:0] timing_code;
    logic [7:0] samp_len;
    logic [7:0] step_len;
    logic [7:0] step_idx;
    logic [7:0] step_phase;
    logic       step_end;
    logic       sar_begin;
    logic       sar_decide;
    logic [3:0] sar_bit;
    logic       transfer;

    assign mode_wr     = ce_in && wr_in && addr_in == sar_adc_pkg::MODE_ADDR;
    assign chan_wr     = ce_in && wr_in && addr_in == sar_adc_pkg::CHAN_ADDR;
    assign cfg_wr      = mode_wr || chan_wr;
    assign run_new     = mode_wr ? wdata_in[sar_adc_pkg::RUN_BIT]
                                 : converter_mode_control_q[sar_adc_pkg::RUN_BIT];
    assign timing_code = converter_mode_control_q[sar_adc_pkg::TIMING_MSB:
                                                  sar_adc_pkg::TIMING_LSB];
    assign samp_len    = sar_adc_pkg::sample_ticks(timing_code); // R10
    // comparison span is always twelve equal steps: ten bits, then settle and transfer
    assign step_len    = 8'((sar_adc_pkg::total_ticks(timing_code) - samp_len)
                            / sar_adc_pkg::COMPARE_STEPS); // R11
    assign step_idx    = timing_code[2] ? (cnt_q >> 2) : (cnt_q >> 1);
    assign step_phase  = timing_code[2] ? {6'h00, cnt_q[1:0]} : {7'h00, cnt_q[0]};
    assign step_end    = step_phase == step_len - 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral tick: conversion timing counts these, not core cycles
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (ce_in) begin
            tick_q <= div_q == sar_adc_pkg::PERIPH_DIV_LAST;
            div_q  <= (div_q == sar_adc_pkg::PERIPH_DIV_LAST) ? 8'h00 : div_q + 8'h01;
        end
    end

    // the comparator answers on its own time; two flops before use
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else if (ce_in) begin
            cmp_meta_q <= cmp_ge_in;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            converter_mode_control_q <= sar_adc_pkg::MODE_RESET; // R07
        end else if (mode_wr) begin
            converter_mode_control_q <= wdata_in[7:0] & sar_adc_pkg::MODE_WRITABLE; // R08
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            input_channel_select_q <= sar_adc_pkg::CHAN_RESET;
        end else if (chan_wr) begin
            input_channel_select_q <= wdata_in[7:0] & sar_adc_pkg::CHAN_WRITABLE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= sar_adc_pkg::RDATA_IDLE;
        end else if (ce_in) begin
            rdata_out <= sar_adc_pkg::RDATA_IDLE;
            if (rd_in) begin
                case (addr_in)
                    sar_adc_pkg::MODE_ADDR:
                        rdata_out <= {8'h00, converter_mode_control_q};
                    sar_adc_pkg::CHAN_ADDR:
                        rdata_out <= {8'h00, input_channel_select_q};
                    sar_adc_pkg::RESULT_WORD_ADDR:
                        rdata_out <= conversion_result_word_q;
                    sar_adc_pkg::RESULT_HIGH_ADDR:
                        rdata_out <= {8'h00, conversion_result_high_byte_q};
                    default:
                        rdata_out <= sar_adc_pkg::RDATA_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        sar_begin  = 1'b0;
        sar_decide = 1'b0;
        sar_bit    = sar_adc_pkg::SAR_TOP_BIT - step_idx[3:0];
        transfer   = 1'b0;
        case (state_q)
            sar_adc_pkg::ST_IDLE: begin
                cnt_d = 8'h00;
            end
            sar_adc_pkg::ST_START_WAIT: begin
                if (tick_q) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == sar_adc_pkg::START_DELAY_TICKS - 8'h01) begin
                        state_d = sar_adc_pkg::ST_SAMPLE; // R22
                        cnt_d   = 8'h00;
                    end
                end
            end
            sar_adc_pkg::ST_SAMPLE: begin
                if (tick_q) begin
                    cnt_d = cnt_q + 8'h01;
                    if (cnt_q == samp_len - 8'h01) begin
                        state_d   = sar_adc_pkg::ST_COMPARE; // R02
                        cnt_d     = 8'h00;
                        sar_begin = 1'b1; // R03
                    end
                end
            end
            sar_adc_pkg::ST_COMPARE: begin
                if (tick_q) begin
                    cnt_d = cnt_q + 8'h01;
                    // one decision in each of the ten bit steps, read after the trial has settled
                    sar_decide = step_end && step_idx < sar_adc_pkg::RESOLVE_STEPS; // R23
                    if (step_end && step_idx == sar_adc_pkg::COMPARE_STEPS - 8'h01) begin
                        transfer = 1'b1; // R11
                        state_d  = sar_adc_pkg::ST_SAMPLE; // R19
                        cnt_d    = 8'h00;
                    end
                end
            end
            default: begin
                state_d = sar_adc_pkg::ST_IDLE;
                cnt_d   = 8'h00;
            end
        endcase
        if (cfg_wr) begin
            // any configuration write throws away the conversion in flight
            state_d    = run_new ? sar_adc_pkg::ST_START_WAIT : sar_adc_pkg::ST_IDLE; // R20 R09
            cnt_d      = 8'h00;
            sar_begin  = 1'b0;
            sar_decide = 1'b0;
            transfer   = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= sar_adc_pkg::ST_IDLE;
            cnt_q   <= 8'h00;
        end else if (ce_in) begin
            state_q <= state_d; // R13
            cnt_q   <= cnt_d;
        end
    end

    approximation_register u_sar (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .begin_in  (sar_begin),
        .decide_in (sar_decide),
        .bit_in    (sar_bit),
        .cmp_ge_in (cmp_sync_q),
        .value_out (sar_value)
    );

    assign trial_code_out = sar_value; // R23

    ////////////////////////////////////////////////////////////////////////////
    // results and outputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conversion_result_word_q      <= {6'h00, sar_adc_pkg::RESULT_RESET};
            conversion_result_high_byte_q <= sar_adc_pkg::RESULT_RESET[9:2];
        end else if (ce_in && transfer) begin
            conversion_result_word_q      <= {6'h00, sar_value}; // R04
            conversion_result_high_byte_q <= sar_value[9:2]; // R05
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conversion_done_irq_out <= 1'b0;
        end else if (ce_in) begin
            conversion_done_irq_out <= transfer; // R06
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_out           <= 1'b0;
            comparator_power_out <= 1'b0;
        end else if (ce_in) begin
            sample_out           <= state_d == sar_adc_pkg::ST_SAMPLE; // R02
            // the run bit alone keeps the comparator up, so a start with it off still works
            comparator_power_out <= converter_mode_control_q[sar_adc_pkg::ENABLE_BIT]
                                 || converter_mode_control_q[sar_adc_pkg::RUN_BIT]; // R12 R15
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            channel_select_out  <= 2'h0;
            port_pin_usable_out <= 4'hf;
        end else if (ce_in) begin
            channel_select_out  <= input_channel_select_q[1:0]; // R01
            port_pin_usable_out <= ~(4'h1 << input_channel_select_q[1:0]); // R01
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [7:0] conv_ticks_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_ticks_q <= 8'h00;
        end else if (ce_in) begin
            if (state_q != sar_adc_pkg::ST_SAMPLE && state_q != sar_adc_pkg::ST_COMPARE) begin
                conv_ticks_q <= 8'h00;
            end else if (transfer) begin
                conv_ticks_q <= 8'h00;
            end else if (tick_q) begin
                conv_ticks_q <= conv_ticks_q + 8'h01;
            end
        end
    end

    sequence s_cfg_write_run;
        cfg_wr && run_new;
    endsequence

    sequence s_restart_wait;
        state_q == sar_adc_pkg::ST_START_WAIT && !sample_out;
    endsequence

    a_conversion_length: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
        transfer && ce_in |->
            conv_ticks_q == sar_adc_pkg::total_ticks(timing_code) - 8'h01)
        else $error("conversion length does not match the timing code");

    a_restart_on_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R20
        s_cfg_write_run |=> s_restart_wait)
        else $error("configuration write did not restart the conversion");

    a_stop_on_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R09
        cfg_wr && !run_new |=> state_q == sar_adc_pkg::ST_IDLE ##1 !sample_out)
        else $error("clearing the run bit did not stop conversion");

    a_hold_while_compare: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R02
        state_q == sar_adc_pkg::ST_COMPARE && $past(state_q) == sar_adc_pkg::ST_COMPARE
            |-> !sample_out)
        else $error("sample-hold left in sample during comparison");

    a_done_with_result: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R06
        transfer && ce_in |=> conversion_done_irq_out
            && conversion_result_word_q[9:0] == $past(sar_value))
        else $error("completion without done pulse or result load");

    a_high_byte_pairs: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R05
        conversion_done_irq_out |->
            conversion_result_high_byte_q == conversion_result_word_q[9:2]
            && conversion_result_word_q[15:10] == 6'h00)
        else $error("result registers disagree");

    a_mode_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R08
        mode_wr |=> (converter_mode_control_q & ~sar_adc_pkg::MODE_WRITABLE) == 8'h00
            && converter_mode_control_q[7] == $past(wdata_in[7]))
        else $error("mode register fields wrong after write");

    a_comparator_power: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
        ce_in && converter_mode_control_q[7] |=> comparator_power_out)
        else $error("comparator unpowered while converting");

    a_channel_routing: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R01
        chan_wr ##1 ce_in |=> port_pin_usable_out[channel_select_out] == 1'b0
            && $countones(port_pin_usable_out) == 3)
        else $error("selected pin still marked as port");

    a_start_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R22
        s_cfg_write_run ##1 (ce_in && !cfg_wr) [*8] |-> state_q != sar_adc_pkg::ST_SAMPLE)
        else $error("sampling began too early after start");

endmodule

// ===== inc/sar_adc_pkg.sv
/*
 * shared constants for the successive-approximation converter control:
 * register addresses, field positions, reset values, timing tables, states.
 * assumes a 100 MHz core clock and a slower peripheral tick derived from it.
 */
package sar_adc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [15:0] MODE_ADDR        = 16'hff80;
    localparam logic [15:0] CHAN_ADDR        = 16'hff81;
    localparam logic [15:0] RESULT_WORD_ADDR = 16'hff18;
    localparam logic [15:0] RESULT_HIGH_ADDR = 16'hff1a;

    localparam logic [7:0]  MODE_RESET       = 8'h00;
    localparam logic [7:0]  CHAN_RESET       = 8'h00;
    localparam logic [7:0]  MODE_WRITABLE    = 8'hb9;
    localparam logic [7:0]  CHAN_WRITABLE    = 8'h03;
    localparam logic [9:0]  RESULT_RESET     = 10'h000;
    localparam logic [15:0] RDATA_IDLE       = 16'h0000;

    localparam int RUN_BIT     = 7;
    localparam int TIMING_MSB  = 5;
    localparam int TIMING_LSB  = 3;
    localparam int ENABLE_BIT  = 0;
    localparam int RESULT_BITS = 10;
    localparam int CHANNELS    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // approximation register
    localparam logic [9:0] SAR_MSB_ONLY = 10'h200;
    localparam logic [3:0] SAR_TOP_BIT  = 4'h9;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CORE_CLK_HZ   = 100_000_000;
    localparam int PERIPH_CLK_HZ = 10_000_000;
    localparam int PERIPH_DIV    = CORE_CLK_HZ / PERIPH_CLK_HZ;
    localparam logic [7:0] PERIPH_DIV_LAST    = 8'(PERIPH_DIV - 1);
    localparam logic [7:0] START_DELAY_TICKS  = 8'h03;
    localparam logic [7:0] COMPARE_STEPS      = 8'h0c;
    localparam logic [7:0] RESOLVE_STEPS      = 8'h0a;

    // sampling length in peripheral ticks per timing code
    function automatic logic [7:0] sample_ticks(input logic [2:0] code);
        logic [7:0] t;
        t = 8'h00;
        case (code)
            3'h0:    t = 8'd12;
            3'h1:    t = 8'd24;
            3'h2:    t = 8'd48;
            3'h3:    t = 8'd88;
            3'h4:    t = 8'd24;
            3'h5:    t = 8'd48;
            3'h6:    t = 8'd96;
            default: t = 8'd176;
        endcase
        return t;
    endfunction

    // whole conversion length in peripheral ticks per timing code
    function automatic logic [7:0] total_ticks(input logic [2:0] code);
        logic [7:0] t;
        t = 8'h00;
        case (code)
            3'h0:    t = 8'd36;
            3'h1:    t = 8'd48;
            3'h2:    t = 8'd72;
            3'h3:    t = 8'd112;
            3'h4:    t = 8'd72;
            3'h5:    t = 8'd96;
            3'h6:    t = 8'd144;
            default: t = 8'd224;
        endcase
        return t;
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_START_WAIT, ST_SAMPLE, ST_COMPARE} conv_state_t;

endpackage

// ===== verif/analog_side_model.sv
/*
 * behavioural analog side of the converter: per-channel input codes, a
 * sample-hold, an ideal tap divider and the comparator.
 * assumes the control block drives sample, trial code, channel and power.
 */
`timescale 1ns/1ns
module analog_side_model (
    input  wire logic            clk_in,
    input  wire logic            sample_in,
    input  wire logic [9:0]      trial_code_in,
    input  wire logic [1:0]      channel_select_in,
    input  wire logic            comparator_power_in,
    input  wire logic [3:0][9:0] vin_in,
    output logic                 cmp_ge_out
);
    logic [9:0] held_q = 10'h000;
    logic       junk_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // hold keeps the last sampled level of the selected input
    always_ff @(posedge clk_in) begin
        if (sample_in) begin
            held_q <= vin_in[channel_select_in];
        end
        junk_q <= ~junk_q;
    end

    // a powered-down comparator gives noise, never a stale decision
    assign cmp_ge_out = comparator_power_in ? (held_q >= trial_code_in) : junk_q;
endmodule

// ===== verif/tb.sv
/*
 * bench for the converter control: register access, timing per code,
 * results per channel, abort on write, stop.
 * assumes the analog side model answers the comparator input.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb;
    logic            clk_in   = 1'b0;
    logic            rst_n_in = 1'b0;
    logic            ce_in    = 1'b1;
    logic            wr_in    = 1'b0;
    logic            rd_in    = 1'b0;
    logic [15:0]     addr_in  = 16'h0000;
    logic [15:0]     wdata_in = 16'h0000;
    logic [15:0]     rdata_out;
    logic [9:0]      trial_code_out;
    logic [1:0]      channel_select_out;
    logic [3:0]      port_pin_usable_out;
    logic            sample_out;
    logic            comparator_power_out;
    logic            conversion_done_irq_out;
    logic            cmp_ge;
    logic [15:0]     d;
    logic [3:0][9:0] vin = {10'h000, 10'h3ff, 10'h15a, 10'h2a5};
    int              s_tab [8] = '{12, 24, 48, 88, 24, 48, 96, 176};
    int              t_tab [8] = '{36, 48, 72, 112, 72, 96, 144, 224};
    int              miscompares = 0;
    int              n_tests = 0;
    int              cycles = 0;
    int              n;
    localparam int   DIV = sar_adc_pkg::PERIPH_DIV;

    sar_adc_control dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .cmp_ge_in(cmp_ge), .rdata_out(rdata_out), .sample_out(sample_out),
        .trial_code_out(trial_code_out), .channel_select_out(channel_select_out),
        .comparator_power_out(comparator_power_out),
        .conversion_done_irq_out(conversion_done_irq_out),
        .port_pin_usable_out(port_pin_usable_out));
    analog_side_model far_u (.clk_in(clk_in), .sample_in(sample_out),
        .trial_code_in(trial_code_out), .channel_select_in(channel_select_out),
        .comparator_power_in(comparator_power_out), .vin_in(vin), .cmp_ge_out(cmp_ge));

    always #5 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////////
    // bus tasks; each leaves one idle cycle so no strobe is set twice per step
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    task automatic wait_done(output int k);
        k = 0;
        do begin @(posedge clk_in); #1; k++; end
        while (conversion_done_irq_out !== 1'b1 && k < 3000);
    endtask

    task automatic wait_sample(input logic lvl, output int k);
        k = 0;
        do begin @(posedge clk_in); #1; k++; end
        while (sample_out !== lvl && k < 3000);
    endtask

    task automatic end_sim;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // whole run is about 21000 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        `CHK("pins", 4'he, port_pin_usable_out)
        rd_reg(sar_adc_pkg::MODE_ADDR);
        `CHK("mode_rst", 16'h0000, d)
        rd_reg(16'hff82);
        `CHK("unmapped", 16'h0000, d)
        wr_reg(sar_adc_pkg::MODE_ADDR, 16'h007f);
        rd_reg(sar_adc_pkg::MODE_ADDR);
        `CHK("mode_mask", 16'h0039, d)
        `CHK("cmp_on", 1'b1, comparator_power_out)
        wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0000);
        repeat (2) @(posedge clk_in);
        #1;
        `CHK("cmp_off", 1'b0, comparator_power_out)
        // strobes while the clock enable is low must leave every register alone
        @(posedge clk_in);
        ce_in <= 1'b0;
        wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0080);
        ce_in <= 1'b1;
        rd_reg(sar_adc_pkg::MODE_ADDR);
        `CHK("ce_freeze", 16'h0000, d)
        wr_reg(sar_adc_pkg::CHAN_ADDR, 16'h00fe);
        rd_reg(sar_adc_pkg::CHAN_ADDR);
        `CHK("chan_mask", 16'h0002, d)
        // every timing code: start delay, sample length, period
        for (int c = 0; c < 8; c++) begin
            wr_reg(sar_adc_pkg::MODE_ADDR, 16'(c * 8 + 1));
            repeat (2) @(posedge clk_in);
            wr_reg(sar_adc_pkg::MODE_ADDR, 16'(c * 8 + 8'h81));
            wait_sample(1'b1, n);
            `CHK("start_delay", 1'b1, (n >= 20 && n <= 31))
            wait_sample(1'b0, n);
            `CHK("sample_len", s_tab[c] * DIV, n)
            wait_done(n);
            wait_done(n);
            `CHK("period", t_tab[c] * DIV, n)
            wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0000);
        end
        // every channel, results; each conversion started with the enable bit clear
        for (int ch = 0; ch < 4; ch++) begin
            wr_reg(sar_adc_pkg::CHAN_ADDR, 16'(ch));
            wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0080);
            wait_done(n);
            wait_done(n);
            `CHK("done", 1'b1, conversion_done_irq_out)
            @(posedge clk_in);
            #1;
            `CHK("done_pulse", 1'b0, conversion_done_irq_out)
            rd_reg(sar_adc_pkg::RESULT_WORD_ADDR);
            `CHK("word", {6'h00, vin[ch]}, d)
            rd_reg(sar_adc_pkg::RESULT_HIGH_ADDR);
            `CHK("high", {8'h00, vin[ch][9:2]}, d)
            `CHK("pins", ~(4'h1 << ch), port_pin_usable_out)
            wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0000);
        end
        // channel write two cycles into the first compare step restarts from the beginning
        wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0001);
        repeat (2) @(posedge clk_in);
        wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0081);
        wait_done(n);
        wait_sample(1'b0, n);
        wr_reg(sar_adc_pkg::CHAN_ADDR, 16'h0001);
        wait_done(n);
        `CHK("restart", 1'b1, (n >= 380 && n <= 392))
        rd_reg(sar_adc_pkg::RESULT_WORD_ADDR);
        `CHK("new_chan", {6'h00, vin[1]}, d)
        // clearing the run bit stops everything
        wr_reg(sar_adc_pkg::MODE_ADDR, 16'h0000);
        n = 0;
        repeat (500) begin
            @(posedge clk_in);
            #1;
            if (sample_out !== 1'b0 || conversion_done_irq_out !== 1'b0) begin
                n++;
            end
        end
        `CHK("stopped", 0, n)
        // asynchronous reset brings results and channel back to their reset values
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd_reg(sar_adc_pkg::RESULT_WORD_ADDR);
        `CHK("word_rst", 16'h0000, d)
        rd_reg(sar_adc_pkg::CHAN_ADDR);
        `CHK("chan_rst", 16'h0000, d)
        end_sim();
    end
endmodule
